/* eas_map.vh */
`ifndef EAS_MAP_VH
`define EAS_MAP_VH
`define EAS_NUM_SETS      4
`define EAS_SET_W         2
`define EAS_MAX_PAIRS     20
`define EAS_PTR_W         5
`define EAS_NUM_CMP       4
`define EAS_NUM_RULES     4
`define EAS_NUM_FLAGS     8
`define EAS_VAL_W         16
`define EAS_EVT_W         5
`define EAS_ACT_W         8
`define EAS_SRC_FLAG      2'h0
`define EAS_SRC_CMP       2'h1
`define EAS_SRC_RULE      2'h2
`define EAS_SRC_TRUE      2'h3
`define EAS_CMP_LT        2'h0
`define EAS_CMP_EQ        2'h1
`define EAS_CMP_GT        2'h2
`define EAS_OP_AND        1'h0
`define EAS_OP_OR         1'h1
`define EAS_RST_PAIRS     5'h01
`define EAS_RST_SET       2'h0
`endif

/* eas_logic_rule.v */
`include "eas_map.vh"
// Three-input boolean rule: inputs optionally inverted, combined by AND or OR,
// result optionally inverted.
module eas_logic_rule (
    input  wire [2:0] i_in,
    input  wire [2:0] i_inv,
    input  wire [2:0] i_use,
    input  wire       i_op,
    input  wire       i_out_inv,
    output wire       o_res
);
    wire [2:0] term;
    wire       and_res;
    wire       or_res;
    // Unused inputs become neutral for the chosen operator
    assign term    = i_in ^ i_inv;
    assign and_res = &(term | ~i_use);
    assign or_res  = |(term & i_use);
    assign o_res   = ((i_op == `EAS_OP_AND) ? and_res : or_res) ^ i_out_inv;
endmodule

/* eas_sequencer.v */
`include "eas_map.vh"
// Function
// - Four configuration sets, one active
// - Inputs or serial command switch active set
// - Active set index shown on panel
// - Action n fires only when event n true
// - After action, pointer advances to next event
// - Only the pointed event is evaluated
// - False event: no action, pointer holds
// - Start evaluates only event 0 until true
// - Pair count configurable from 1 to 20
// - After last pair, wrap to slot 0
// - Event true from flag, rule or comparator
// - Comparator checks variable against preset
// - Rule combines three inputs, AND OR NOT
module eas_sequencer #(
    parameter NPAIR = `EAS_MAX_PAIRS,
    parameter NCMP  = `EAS_NUM_CMP,
    parameter NRULE = `EAS_NUM_RULES,
    parameter NFLAG = `EAS_NUM_FLAGS,
    parameter VW    = `EAS_VAL_W
) (
    input  wire                          i_clk,
    input  wire                          i_srst,
    input  wire                          i_scan,
    input  wire                          i_run,
    input  wire [`EAS_SET_W-1:0]         i_set_din,
    input  wire                          i_set_din_en,
    input  wire [`EAS_SET_W-1:0]         i_set_cmd,
    input  wire                          i_set_cmd_stb,
    input  wire [NFLAG-1:0]              i_flags,
    input  wire [NCMP*VW-1:0]            i_cmp_var,
    input  wire [3:0]                    i_timers,
    input  wire [3:0]                    i_din,
    input  wire                          i_cfg_we,
    input  wire [`EAS_SET_W-1:0]         i_cfg_set,
    input  wire [`EAS_PTR_W-1:0]         i_cfg_idx,
    input  wire [`EAS_EVT_W-1:0]         i_cfg_evt,
    input  wire [`EAS_ACT_W-1:0]         i_cfg_act,
    input  wire                          i_cfg_cnt_we,
    input  wire [`EAS_PTR_W-1:0]         i_cfg_cnt,
    input  wire                          i_cmp_we,
    input  wire [1:0]                    i_cmp_idx,
    input  wire [VW-1:0]                 i_cmp_preset,
    input  wire [1:0]                    i_cmp_mode,
    input  wire                          i_rule_we,
    input  wire [1:0]                    i_rule_idx,
    input  wire [17:0]                   i_rule_cfg,
    output reg  [`EAS_SET_W-1:0]         o_panel_set,
    output reg  [`EAS_PTR_W-1:0]         o_ptr,
    output reg                           o_act_stb,
    output reg  [`EAS_ACT_W-1:0]         o_act_code,
    output reg  [`EAS_PTR_W-1:0]         o_act_idx
);
    localparam NSETS = `EAS_NUM_SETS;
    localparam NSLOT = NSETS * NPAIR;

    // Set pins, digital inputs and flags are from outside: two stages; panel command is used unsynchronized
    reg [`EAS_SET_W-1:0] din_s1_r;
    reg [`EAS_SET_W-1:0] din_s2_r;
    reg [`EAS_SET_W-1:0] din_s3_r;
    reg                  din_en_s1_r;
    reg                  din_en_s2_r;
    reg [3:0]            dio_s1_r;
    reg [3:0]            dio_s2_r;
    reg [NFLAG-1:0]      flg_s1_r;
    reg [NFLAG-1:0]      flg_s2_r;

    // Per-set tables; comparator and rule settings shared by all sets
    reg [`EAS_EVT_W-1:0] evt_mem [0:NSLOT-1];
    reg [`EAS_ACT_W-1:0] act_mem [0:NSLOT-1];
    reg [`EAS_PTR_W-1:0] cnt_mem [0:NSETS-1];
    reg [VW-1:0]         cmp_pre_r [0:NCMP-1];
    reg [1:0]            cmp_mode_r [0:NCMP-1];
    reg [17:0]           rule_cfg_r [0:NRULE-1];

    reg [`EAS_SET_W-1:0] set_r;
    reg [`EAS_SET_W-1:0] set_nxt;
    reg [`EAS_PTR_W-1:0] ptr_r;
    reg [`EAS_PTR_W-1:0] ptr_nxt;
    reg                  running_r;

    wire [NCMP-1:0]  cmp_res;
    wire [NRULE-1:0] rule_res;
    wire [15:0]      rule_src;
    integer          k;

    function [6:0] slot_of;
        input [`EAS_SET_W-1:0] s;
        input [`EAS_PTR_W-1:0] p;
        begin
            slot_of = s * NPAIR[6:0] + {2'h0, p};
        end
    endfunction

    // Stored count clamped into 1..NPAIR
    function [`EAS_PTR_W-1:0] clamp_cnt;
        input [`EAS_PTR_W-1:0] c;
        begin
            if (c == {`EAS_PTR_W{1'b0}})
                clamp_cnt = `EAS_RST_PAIRS;
            else if (c > NPAIR[`EAS_PTR_W-1:0])
                clamp_cnt = NPAIR[`EAS_PTR_W-1:0];
            else
                clamp_cnt = c;
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NCMP; g = g + 1) begin : gen_cmp
            wire [VW-1:0] v = i_cmp_var[g*VW +: VW];
            assign cmp_res[g] = (cmp_mode_r[g] == `EAS_CMP_LT) ? (v < cmp_pre_r[g]) :
                                (cmp_mode_r[g] == `EAS_CMP_EQ) ? (v == cmp_pre_r[g]) :
                                (v > cmp_pre_r[g]);
        end
        for (g = 0; g < NRULE; g = g + 1) begin : gen_rule
            wire [17:0] c = rule_cfg_r[g];
            // Each input field: 4-bit source index into rule_src
            eas_logic_rule u_rule (
                .i_in      ({rule_src[c[11:8]], rule_src[c[7:4]], rule_src[c[3:0]]}),
                .i_inv     (c[14:12]),
                .i_use     ({c[17:16], 1'b1}),
                .i_op      (c[15]),
                .i_out_inv (1'b0),
                .o_res     (rule_res[g])
            );
        end
    endgenerate

    // Rule input pool: timers, comparators, digital inputs, status flags
    assign rule_src = {flg_s2_r[3:0], dio_s2_r, cmp_res[3:0], i_timers};

    wire [`EAS_EVT_W-1:0] cur_evt = evt_mem[slot_of(set_r, ptr_r)];
    wire [`EAS_PTR_W-1:0] cur_cnt = clamp_cnt(cnt_mem[set_r]);
    reg                   evt_true;

    always @* begin
        case (cur_evt[4:3])
            `EAS_SRC_FLAG: evt_true = flg_s2_r[cur_evt[2:0]];
            `EAS_SRC_CMP:  evt_true = cmp_res[cur_evt[1:0]];
            `EAS_SRC_RULE: evt_true = rule_res[cur_evt[1:0]];
            default:       evt_true = 1'b1;
        endcase
    end

    always @* begin
        set_nxt = set_r;
        if (i_set_cmd_stb)
            set_nxt = i_set_cmd;
        // Pin-selected set taken only once two samples agree
        else if (din_en_s2_r && din_s2_r == din_s3_r)
            set_nxt = din_s2_r;
    end

    always @* begin
        ptr_nxt = ptr_r;
        if (ptr_r + 5'h01 >= cur_cnt)
            ptr_nxt = {`EAS_PTR_W{1'b0}};
        else
            ptr_nxt = ptr_r + 5'h01;
    end

    always @(posedge i_clk) begin
        din_s1_r    <= i_set_din;
        din_s2_r    <= din_s1_r;
        din_s3_r    <= din_s2_r;
        din_en_s1_r <= i_set_din_en;
        din_en_s2_r <= din_en_s1_r;
        dio_s1_r    <= i_din;
        dio_s2_r    <= dio_s1_r;
        flg_s1_r    <= i_flags;
        flg_s2_r    <= flg_s1_r;
        if (i_cfg_we)
            evt_mem[slot_of(i_cfg_set, i_cfg_idx)] <= i_cfg_evt;
        if (i_cfg_we)
            act_mem[slot_of(i_cfg_set, i_cfg_idx)] <= i_cfg_act;
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            for (k = 0; k < NSETS; k = k + 1)
                cnt_mem[k] <= `EAS_RST_PAIRS;
            for (k = 0; k < NCMP; k = k + 1) begin
                cmp_pre_r[k]  <= {VW{1'b0}};
                cmp_mode_r[k] <= `EAS_CMP_GT;
            end
            for (k = 0; k < NRULE; k = k + 1)
                rule_cfg_r[k] <= 18'h00000;
        end else begin
            if (i_cfg_cnt_we)
                cnt_mem[i_cfg_set] <= i_cfg_cnt;
            if (i_cmp_we) begin
                cmp_pre_r[i_cmp_idx]  <= i_cmp_preset;
                cmp_mode_r[i_cmp_idx] <= i_cmp_mode;
            end
            if (i_rule_we)
                rule_cfg_r[i_rule_idx] <= i_rule_cfg;
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            set_r       <= `EAS_RST_SET;
            ptr_r       <= {`EAS_PTR_W{1'b0}};
            running_r   <= 1'b0;
            o_panel_set <= `EAS_RST_SET;
            o_ptr       <= {`EAS_PTR_W{1'b0}};
            o_act_stb   <= 1'b0;
            o_act_code  <= {`EAS_ACT_W{1'b0}};
            o_act_idx   <= {`EAS_PTR_W{1'b0}};
        end else begin
            set_r       <= set_nxt;
            o_panel_set <= set_nxt;
            o_act_stb   <= 1'b0;
            running_r   <= i_run;
            if (!i_run || !running_r || set_nxt != set_r) begin
                ptr_r <= {`EAS_PTR_W{1'b0}};
            end else if (i_scan && evt_true) begin
                o_act_stb  <= 1'b1;
                o_act_code <= act_mem[slot_of(set_r, ptr_r)];
                o_act_idx  <= ptr_r;
                ptr_r      <= ptr_nxt;
            end
            // False event on a scan leaves pointer alone
            o_ptr <= ptr_r;
        end
    end
endmodule

/* eas_sequencer_monitor.sv */
module eas_sequencer_monitor (
    input wire       i_clk,
    input wire       i_srst,
    input wire       i_scan,
    input wire       i_run,
    input wire       i_set_din_en,
    input wire       i_set_cmd_stb,
    input wire [1:0] i_set_cmd,
    input wire [1:0] o_panel_set,
    input wire [4:0] o_ptr,
    input wire       o_act_stb,
    input wire [7:0] o_act_code,
    input wire [4:0] o_act_idx
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);
    // Quiet cycle, then pointer back at slot 0
    sequence restart_s;
        !o_act_stb ##1 o_ptr == 5'h00;
    endsequence
    act_cause_a: assert property (
        o_act_stb |-> $past(i_scan) && $past(i_run) && $past(i_run, 2)
        && (!$past(i_set_cmd_stb) || $past(i_set_cmd) == $past(o_panel_set)))
        else $error("action without scan");
    act_idx_a: assert property (o_act_stb |-> o_act_idx == o_ptr)
        else $error("action index not pointer");
    ptr_hold_a: assert property ($changed(o_ptr) |-> $past(o_act_stb) || o_ptr == 5'h00)
        else $error("pointer moved without action");
    ptr_step_a: assert property (
        o_act_stb |=> o_ptr == $past(o_act_idx) + 5'h01 || o_ptr == 5'h00)
        else $error("pointer did not advance");
    code_hold_a: assert property (
        !o_act_stb && !$past(i_srst) |-> $stable(o_act_code) && $stable(o_act_idx))
        else $error("action output moved");
    panel_cmd_a: assert property (i_set_cmd_stb |=> o_panel_set == $past(i_set_cmd))
        else $error("panel missed set command");
    panel_src_a: assert property ($changed(o_panel_set) && !$past(i_srst) |->
        $past(i_set_cmd_stb) || $past(i_set_din_en, 2) || $past(i_set_din_en, 3)
        || $past(i_set_din_en, 4)) else $error("set changed without request");
    set_restart_a: assert property (
        i_set_cmd_stb && i_set_cmd != o_panel_set |=> restart_s)
        else $error("set change kept pointer");
    run_restart_a: assert property (!i_run |=> restart_s)
        else $error("pointer kept while stopped");
endmodule

bind eas_sequencer eas_sequencer_monitor u_mon (
    .i_clk, .i_srst, .i_scan, .i_run, .i_set_din_en, .i_set_cmd_stb, .i_set_cmd,
    .o_panel_set, .o_ptr, .o_act_stb, .o_act_code, .o_act_idx
);

/* eas_sequencer_tb.sv */
module eas_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0, i_srst = 1'b1, i_scan = 1'b0, i_run = 1'b0;
    logic        i_set_din_en = 1'b0, i_set_cmd_stb = 1'b0, i_cfg_we = 1'b0;
    logic        i_cfg_cnt_we = 1'b0, i_cmp_we = 1'b0, i_rule_we = 1'b0;
    logic [1:0]  i_set_din = 2'h0, i_set_cmd = 2'h0, i_cfg_set = 2'h0;
    logic [1:0]  i_cmp_idx = 2'h0, i_cmp_mode = 2'h0, i_rule_idx = 2'h0;
    logic [7:0]  i_flags = 8'h00, i_cfg_act = 8'h00;
    logic [63:0] i_cmp_var = 64'h0;
    logic [3:0]  i_timers = 4'h0, i_din = 4'h0;
    logic [4:0]  i_cfg_idx = 5'h00, i_cfg_evt = 5'h00, i_cfg_cnt = 5'h00;
    logic [15:0] i_cmp_preset = 16'h0000;
    logic [17:0] i_rule_cfg = 18'h00000;
    wire  [1:0]  o_panel_set;
    wire  [4:0]  o_ptr, o_act_idx;
    wire         o_act_stb;
    wire  [7:0]  o_act_code;
    // Rows: cmp var, flag0, timer0, action pulse, action index, pointer after
    logic [28:0] rows [7] = '{
        {16'h00ff, 3'b110, 5'h00, 5'h00}, {16'h0100, 3'b111, 5'h00, 5'h01},
        {16'h0100, 3'b010, 5'h00, 5'h01}, {16'h0100, 3'b111, 5'h01, 5'h02},
        {16'h0100, 3'b110, 5'h01, 5'h02}, {16'h0100, 3'b101, 5'h02, 5'h00},
        {16'h0101, 3'b100, 5'h02, 5'h00}};
    int          fail_count = 0, cmp_count = 0, cyc = 0;

    eas_sequencer uut (
        .i_clk, .i_srst, .i_scan, .i_run, .i_set_din, .i_set_din_en, .i_set_cmd,
        .i_set_cmd_stb, .i_flags, .i_cmp_var, .i_timers, .i_din, .i_cfg_we, .i_cfg_set,
        .i_cfg_idx, .i_cfg_evt, .i_cfg_act, .i_cfg_cnt_we, .i_cfg_cnt, .i_cmp_we,
        .i_cmp_idx, .i_cmp_preset, .i_cmp_mode, .i_rule_we, .i_rule_idx, .i_rule_cfg,
        .o_panel_set, .o_ptr, .o_act_stb, .o_act_code, .o_act_idx
    );

    initial begin
        forever #10 i_clk = ~i_clk;
    end

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("Error %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [1:0] s, input logic [4:0] x, input logic [4:0] e,
                      input logic [7:0] a, input logic cnt);
        @(negedge i_clk);
        {i_cfg_set, i_cfg_idx, i_cfg_cnt, i_cfg_evt, i_cfg_act} = {s, x, x, e, a};
        i_cfg_we = !cnt;
        i_cfg_cnt_we = cnt;
        @(negedge i_clk);
        i_cfg_we = 1'b0;
        i_cfg_cnt_we = 1'b0;
    endtask

    task automatic scan();
        @(negedge i_clk);
        i_scan = 1'b1;
        @(negedge i_clk);
        i_scan = 1'b0;
    endtask

    task automatic set_cmd(input logic [1:0] s);
        @(negedge i_clk);
        i_set_cmd = s;
        i_set_cmd_stb = 1'b1;
        @(negedge i_clk);
        i_set_cmd_stb = 1'b0;
    endtask

    task final_report;
        if (fail_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        repeat (12) @(negedge i_clk);
        i_srst = 1'b0;
        chk(o_ptr, 5'h00);
        chk(o_panel_set, 2'h0);
        wr(2'h0, 5'h03, 5'h00, 8'h00, 1'b1);
        wr(2'h0, 5'h00, 5'h08, 8'h10, 1'b0);
        wr(2'h0, 5'h01, 5'h00, 8'h11, 1'b0);
        wr(2'h0, 5'h02, 5'h10, 8'h12, 1'b0);
        wr(2'h1, 5'h1f, 5'h00, 8'h00, 1'b1);
        for (int i = 0; i < 20; i++)
            wr(2'h1, i[4:0], 5'h18, 8'h20 + i[7:0], 1'b0);
        wr(2'h2, 5'h00, 5'h00, 8'h00, 1'b1);
        wr(2'h2, 5'h00, 5'h18, 8'h30, 1'b0);
        // Comparator 0 equal to 0x100, rule 0 is NOT timer 0
        {i_cmp_preset, i_cmp_mode, i_rule_cfg} = {16'h0100, 2'h1, 18'h01000};
        {i_cmp_we, i_rule_we} = 2'b11;
        @(negedge i_clk);
        {i_cmp_we, i_rule_we, i_run} = 3'b001;
        repeat (3) @(negedge i_clk);
        for (int r = 0; r < 7; r++) begin
            {i_cmp_var[15:0], i_flags[0], i_timers[0]} = rows[r][28:11];
            repeat (4) @(negedge i_clk);
            scan();
            chk(o_act_stb, rows[r][10]);
            chk(o_act_idx, rows[r][9:5]);
            if (rows[r][10])
                chk(o_act_code, 8'h10 + rows[r][9:5]);
            @(negedge i_clk);
            chk(o_ptr, rows[r][4:0]);
        end
        set_cmd(2'h1);
        chk(o_panel_set, 2'h1);
        i_scan = 1'b1;
        for (int k = 0; k < 20; k++) begin
            @(negedge i_clk);
            if (k == 19)
                i_scan = 1'b0;
            chk(o_act_idx, k);
            chk(o_act_code, 8'h20 + k);
        end
        @(negedge i_clk);
        chk(o_ptr, 5'h00);
        {i_set_din, i_set_din_en} = 3'b101;
        repeat (6) @(negedge i_clk);
        i_set_din_en = 1'b0;
        chk(o_panel_set, 2'h2);
        for (int k = 0; k < 2; k++) begin
            scan();
            chk(o_act_stb, 1'b1);
            chk(o_act_code, 8'h30);
        end
        set_cmd(2'h1);
        scan();
        chk(o_act_code, 8'h20);
        wr(2'h3, 5'h02, 5'h00, 8'h00, 1'b1);
        wr(2'h3, 5'h00, 5'h09, 8'h40, 1'b0);
        wr(2'h3, 5'h01, 5'h11, 8'h41, 1'b0);
        // Comparator 1 below 0x50; rule 1 is digital input 0 OR comparator 2
        {i_cmp_idx, i_cmp_preset, i_cmp_mode} = {2'h1, 16'h0050, 2'h0};
        {i_rule_idx, i_rule_cfg, i_cmp_var[31:16]} = {2'h1, 18'h18068, 16'h0060};
        {i_cmp_we, i_rule_we} = 2'b11;
        @(negedge i_clk);
        {i_cmp_we, i_rule_we} = 2'b00;
        set_cmd(2'h3);
        chk(o_panel_set, 2'h3);
        scan();
        chk(o_act_stb, 1'b0);
        i_cmp_var[31:16] = 16'h004f;
        scan();
        chk(o_act_stb, 1'b1);
        chk(o_act_code, 8'h40);
        scan();
        chk(o_act_stb, 1'b0);
        i_din = 4'h1;
        @(negedge i_clk);
        scan();
        chk(o_act_code, 8'h41);
        i_din = 4'h0;
        scan();
        chk(o_act_code, 8'h40);
        i_cmp_var[47:32] = 16'h0001;
        scan();
        chk(o_act_stb, 1'b1);
        chk(o_act_code, 8'h41);
        scan();
        @(negedge i_clk);
        chk(o_ptr, 5'h01);
        i_run = 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_ptr, 5'h00);
        i_srst = 1'b1;
        repeat (2) @(negedge i_clk);
        i_srst = 1'b0;
        chk(o_panel_set, 2'h0);
        chk(o_act_stb, 1'b0);
        chk(o_act_code, 8'h00);
        final_report();
    end
endmodule
